/* logic/uspt_pkg.sv */
package uspt_pkg;

	// register indices, byte address is four times the index
	localparam logic [9:0]  IDX_POWER_BAUD   = 10'h087;
	localparam logic [9:0]  IDX_SERIAL_CTRL  = 10'h098;
	localparam logic [9:0]  IDX_SERIAL_DATA  = 10'h099;
	localparam logic [9:0]  IDX_TIMER1_DIV   = 10'h0A0;
	localparam logic [9:0]  IDX_TIMER2_DIV   = 10'h0A1;
	localparam logic [9:0]  IDX_TIMER_CTRL   = 10'h0A2;

	// field positions
	localparam int          POS_BAUD_DOUBLE  = 7;
	localparam int          POS_T1_RUN       = 0;
	localparam int          POS_T2_TX_CLK    = 4;
	localparam int          POS_T2_RX_CLK    = 5;

	// values after reset
	localparam logic [7:0]  SERIAL_CONTROL_STATUS_RESET       = 8'h00;
	localparam logic [7:0]  SERIAL_DATA_BUFFER_RESET       = 8'h00;
	localparam logic [15:0] DIV_RESET        = 16'h0000;
	localparam logic [7:0]  TCTL_RESET       = 8'h00;

	// mode codes
	localparam logic [1:0]  MODE_SYNC        = 2'b00;
	localparam logic [1:0]  MODE_TEN         = 2'b01;
	localparam logic [1:0]  MODE_ELEVEN      = 2'b11;

	// cycle counts
	localparam logic [3:0]  M0_HALF_SLOW     = 4'h6;
	localparam logic [3:0]  M0_HALF_FAST     = 4'h2;
	localparam logic [3:0]  FRAME_BITS_TEN   = 4'hA;
	localparam logic [3:0]  FRAME_BITS_ELEV  = 4'hB;
	localparam logic [3:0]  SYNC_BITS        = 4'h8;

	typedef struct packed {
		logic mode_select_hi;
		logic mode_select_lo;
		logic address_filter_or_rate;
		logic receive_enable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic transmit_done_flag;
		logic receive_done_flag;
	} uspt_serial_control_status_s;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b001,
		TX_ASYNC = 3'b010,
		TX_SYNC  = 3'b100
	} uspt_tx_state_e;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_ASYNC = 3'b010,
		RX_SYNC  = 3'b100
	} uspt_rx_state_e;

endpackage

/* logic/uspt_serial_port.sv */
`timescale 1ns/1ps
// Operation
// - mode bits pick shift, ten or eleven-bit
// - mode 0: data on rx, clock on tx
// - mode 1: start, eight data, stop
// - mode 3: start, eight, ninth, stop
// - mode 3 sends programmed ninth bit
// - mode 3 stores received ninth bit
// - address filter gates receive flag on ninth
// - mode 0 shift rate twelfth or quarter
// - receive starts only while receive enable set, clearing it aborts modes 1 and 3 but not mode 0
// - data write loads shifter, starts sending in modes 0, 1 and 3 when idle
// - data read returns receive latch
// - done flags set by hardware, software clears
// - baud double divides rate by sixteen
// - timer 2 chosen when either select set
// - timer 1 divisor sets baud rate
// - timer 2 reload sets baud rate
module uspt_serial_port
	import uspt_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        rx_i,
	output logic             rx_o,
	output logic             rx_oe_o,
	output logic             tx_o
);

	function automatic logic reg_hit(input logic [11:0] a, input logic [9:0] idx);
		return (a[1:0] == 2'b00) && (a[11:2] == idx);
	endfunction

	uspt_serial_control_status_s     serial_control_status;
	uspt_tx_state_e tx_state;
	uspt_rx_state_e rx_state;
	logic [7:0]     rx_latch;
	logic           baud_double_bit;
	logic [15:0]    timer1_div;
	logic [15:0]    timer2_div;
	logic [7:0]     timer2_control;
	logic           rx_meta;
	logic           rx_sync;
	logic           rx_prev;
	logic [19:0]    baud_cnt;
	logic [19:0]    rx_cnt;
	logic [3:0]     m0_cnt;
	logic           sclk;
	logic [10:0]    tx_shift;
	logic [3:0]     tx_bits;
	logic           tx_line;
	logic           m0_data;
	logic [9:0]     rx_shift;
	logic [3:0]     rx_bits;
	logic           tx_done_set;
	logic           rx_done_set;
	logic           rx_ninth_set;
	logic           rx_ninth_val;
	logic [31:0]    read_val;
	logic           mapped;

	wire logic [1:0]  mode     = {serial_control_status.mode_select_hi, serial_control_status.mode_select_lo};
	wire logic        is_sync  = (mode == MODE_SYNC);
	wire logic        is_async = (mode == MODE_TEN) || (mode == MODE_ELEVEN);
	wire logic        is_nine  = (mode == MODE_ELEVEN);
	wire logic        setup    = psel_i & ~penable_i;
	wire logic        wr_en    = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
	wire logic        wr_serial_control_status  = wr_en & reg_hit(paddr_i, IDX_SERIAL_CTRL);
	wire logic        wr_serial_data_buffer  = wr_en & reg_hit(paddr_i, IDX_SERIAL_DATA);

	// baud source and bit period
	wire logic        use_t2   = timer2_control[POS_T2_TX_CLK] | timer2_control[POS_T2_RX_CLK];
	wire logic [15:0] divisor  = use_t2 ? timer2_div : timer1_div;
	wire logic [19:0] bit_period = baud_double_bit ? {divisor, 4'h0} : {4'h0, divisor};
	wire logic        baud_tick = is_async & (baud_cnt == 20'h00000);

	// mode 0 half-period pulses
	wire logic [3:0]  m0_half  = serial_control_status.address_filter_or_rate ? M0_HALF_FAST : M0_HALF_SLOW;
	wire logic        m0_busy  = (tx_state == TX_SYNC) || (rx_state == RX_SYNC);
	wire logic        m0_step  = m0_busy & (m0_cnt == 4'h1);
	wire logic        m0_fall  = m0_step & sclk;
	wire logic        m0_rise  = m0_step & ~sclk;

	// register read mux
	always_comb begin
		read_val = 32'h00000000;
		mapped   = 1'b1;
		if (reg_hit(paddr_i, IDX_SERIAL_CTRL)) begin
			read_val = {24'h000000, serial_control_status};
		end else if (reg_hit(paddr_i, IDX_SERIAL_DATA)) begin
			read_val = {24'h000000, rx_latch};
		end else if (reg_hit(paddr_i, IDX_POWER_BAUD)) begin
			read_val = 32'h00000000;
		end else if (reg_hit(paddr_i, IDX_TIMER1_DIV)) begin
			read_val = {16'h0000, timer1_div};
		end else if (reg_hit(paddr_i, IDX_TIMER2_DIV)) begin
			read_val = {16'h0000, timer2_div};
		end else if (reg_hit(paddr_i, IDX_TIMER_CTRL)) begin
			read_val = {24'h000000, timer2_control};
		end else begin
			mapped = 1'b0;
		end
	end

	// apb answer, one access cycle
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= setup;
			pslverr_o <= setup & ~mapped;
			if (setup & ~pwrite_i) begin
				prdata_o <= read_val;
			end
		end
	end

	// control and status register
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			serial_control_status <= SERIAL_CONTROL_STATUS_RESET;
		end else begin
			if (wr_serial_control_status) begin
				serial_control_status <= pwdata_i[7:0];
			end
			if (rx_ninth_set) begin
				serial_control_status.rx_ninth_bit <= rx_ninth_val;
			end
			if (tx_done_set) begin
				serial_control_status.transmit_done_flag <= 1'b1;
			end
			if (rx_done_set) begin
				serial_control_status.receive_done_flag <= 1'b1;
			end
		end
	end

	// baud double and divisor registers
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			baud_double_bit <= 1'b0;
			timer1_div      <= DIV_RESET;
			timer2_div      <= DIV_RESET;
			timer2_control  <= TCTL_RESET;
		end else if (wr_en) begin
			if (reg_hit(paddr_i, IDX_POWER_BAUD)) begin
				baud_double_bit <= pwdata_i[POS_BAUD_DOUBLE];
			end
			if (reg_hit(paddr_i, IDX_TIMER1_DIV)) begin
				timer1_div <= pwdata_i[15:0];
			end
			if (reg_hit(paddr_i, IDX_TIMER2_DIV)) begin
				timer2_div <= pwdata_i[15:0];
			end
			if (reg_hit(paddr_i, IDX_TIMER_CTRL)) begin
				timer2_control <= pwdata_i[7:0];
			end
		end
	end

	// pin synchroniser
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_meta <= rx_i;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	// free running bit tick divider
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			baud_cnt <= 20'h00000;
		end else if (!is_async || baud_cnt == 20'h00000) begin
			baud_cnt <= bit_period - 20'h00001;
		end else begin
			baud_cnt <= baud_cnt - 20'h00001;
		end
	end

	// mode 0 shift clock
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			m0_cnt <= M0_HALF_SLOW;
			sclk   <= 1'b1;
		end else if (!m0_busy) begin
			m0_cnt <= m0_half;
			sclk   <= 1'b1;
		end else if (m0_step) begin
			m0_cnt <= m0_half;
			sclk   <= ~sclk;
		end else begin
			m0_cnt <= m0_cnt - 4'h1;
		end
	end

	// transmitter
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			tx_state    <= TX_IDLE;
			tx_shift    <= 11'h7FF;
			tx_bits     <= 4'h0;
			tx_line     <= 1'b1;
			m0_data     <= 1'b1;
			tx_done_set <= 1'b0;
		end else begin
			tx_done_set <= 1'b0;
			unique case (tx_state)
				TX_IDLE: begin
					tx_line <= 1'b1;
					if (wr_serial_data_buffer && is_async) begin
						// stop, ninth, data, start; lsb leaves first
						tx_shift <= {1'b1, is_nine ? serial_control_status.tx_ninth_bit : 1'b1, pwdata_i[7:0], 1'b0};
						tx_bits  <= is_nine ? FRAME_BITS_ELEV : FRAME_BITS_TEN;
						tx_state <= TX_ASYNC;
					end else if (wr_serial_data_buffer && is_sync && rx_state == RX_IDLE) begin
						tx_shift <= {3'b111, pwdata_i[7:0]};
						tx_bits  <= SYNC_BITS;
						tx_state <= TX_SYNC;
					end
				end
				TX_ASYNC: begin
					if (!is_async) begin
						tx_state <= TX_IDLE;
					end else if (baud_tick) begin
						if (tx_bits != 4'h0) begin
							tx_line  <= tx_shift[0];
							tx_shift <= {1'b1, tx_shift[10:1]};
							tx_bits  <= tx_bits - 4'h1;
						end else begin
							tx_done_set <= 1'b1;
							tx_state    <= TX_IDLE;
						end
					end
				end
				TX_SYNC: begin
					if (!is_sync) begin
						tx_state <= TX_IDLE;
					end else if (m0_fall) begin
						m0_data  <= tx_shift[0];
						tx_shift <= {1'b1, tx_shift[10:1]};
					end else if (m0_rise) begin
						tx_bits <= tx_bits - 4'h1;
						if (tx_bits == 4'h1) begin
							tx_done_set <= 1'b1;
							tx_state    <= TX_IDLE;
						end
					end
				end
				default: begin
					tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	// receiver
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			rx_state     <= RX_IDLE;
			rx_cnt       <= 20'h00000;
			rx_shift     <= 10'h000;
			rx_bits      <= 4'h0;
			rx_latch     <= SERIAL_DATA_BUFFER_RESET;
			rx_done_set  <= 1'b0;
			rx_ninth_set <= 1'b0;
			rx_ninth_val <= 1'b0;
		end else begin
			rx_done_set  <= 1'b0;
			rx_ninth_set <= 1'b0;
			unique case (rx_state)
				RX_IDLE: begin
					if (is_async && serial_control_status.receive_enable && rx_prev && !rx_sync) begin
						rx_cnt   <= {1'b0, bit_period[19:1]};
						rx_bits  <= is_nine ? FRAME_BITS_ELEV : FRAME_BITS_TEN;
						rx_state <= RX_ASYNC;
					end else if (is_sync && serial_control_status.receive_enable && !serial_control_status.receive_done_flag
						&& tx_state == TX_IDLE && !wr_serial_data_buffer) begin
						rx_bits  <= SYNC_BITS;
						rx_state <= RX_SYNC;
					end
				end
				RX_ASYNC: begin
					if (!is_async || !serial_control_status.receive_enable) begin
						rx_state <= RX_IDLE;
					end else if (rx_cnt != 20'h00000) begin
						rx_cnt <= rx_cnt - 20'h00001;
					end else begin
						rx_cnt  <= bit_period - 20'h00001;
						rx_bits <= rx_bits - 4'h1;
						if ((rx_bits == FRAME_BITS_ELEV || rx_bits == FRAME_BITS_TEN)
							&& rx_bits == (is_nine ? FRAME_BITS_ELEV : FRAME_BITS_TEN)) begin
							// false start: line back high at mid start bit
							if (rx_sync) begin
								rx_state <= RX_IDLE;
							end
						end else if (rx_bits == 4'h1) begin
							rx_state <= RX_IDLE;
							if (is_nine) begin
								rx_ninth_set <= 1'b1;
								rx_ninth_val <= rx_shift[9];
								rx_latch     <= rx_shift[8:1];
								rx_done_set  <= !serial_control_status.address_filter_or_rate || rx_shift[9];
							end else begin
								rx_latch    <= rx_shift[9:2];
								rx_done_set <= 1'b1;
							end
						end else begin
							rx_shift <= {rx_sync, rx_shift[9:1]};
						end
					end
				end
				RX_SYNC: begin
					if (!is_sync) begin
						rx_state <= RX_IDLE;
					end else if (m0_rise) begin
						rx_shift <= {rx_sync, rx_shift[9:1]};
						rx_bits  <= rx_bits - 4'h1;
						if (rx_bits == 4'h1) begin
							rx_latch    <= {rx_sync, rx_shift[9:3]};
							rx_done_set <= 1'b1;
							rx_state    <= RX_IDLE;
						end
					end
				end
				default: begin
					rx_state <= RX_IDLE;
				end
			endcase
		end
	end

	// registered pin drivers
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			tx_o    <= 1'b1;
			rx_o    <= 1'b1;
			rx_oe_o <= 1'b0;
		end else begin
			tx_o    <= is_sync ? sclk : tx_line;
			rx_o    <= m0_data;
			rx_oe_o <= (tx_state == TX_SYNC);
		end
	end

endmodule // uspt_serial_port

/* test/test_uspt_serial_port.sv */
`timescale 1ns/1ps
module test_uspt_serial_port;
	import uspt_pkg::*;
	logic        sys_clk_i = 1'b0;
	logic        resetn_i  = 1'b0;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [11:0] paddr_i   = 12'h000;
	logic [31:0] pwdata_i  = 32'h0;
	logic [3:0]  pstrb_i   = 4'hF;
	logic [31:0] prdata_o, d;
	logic        pready_o, pslverr_o, rx_o, rx_oe_o, tx_o, line, busy, rx_i;
	logic        send = 1'b0, nine = 1'b0, ninth = 1'b0, m0 = 1'b0;
	logic [7:0]  sdata = 8'h00, sh;
	logic [15:0] per = 16'd32;
	logic [31:0] seed = 32'd98;
	logic [10:0] got, tq[$];
	logic [31:0] rq[$];
	int          fail_count = 0, comparisons = 0, half = 6, k = 0, lowc = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	assign rx_i = rx_oe_o ? rx_o : line;
	uspt_serial_port i_uspt_serial_port (.sys_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .rx_i, .rx_o, .rx_oe_o, .tx_o);
	uspt_serial_partner i_uspt_serial_partner (.sys_clk_i, .send_i(send), .data_i(sdata), .ninth_i(ninth),
		.nine_i(nine), .period_i(per), .line_o(line), .busy_o(busy));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wait_done(input int n, input int lim);
		if (n >= lim) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] e);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		if (!wr) rq.push_back(e);
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin @(posedge sys_clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
		wait_done(n, 50);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (tq.size() > 0 && n < 40000) begin @(posedge sys_clk_i); n++; end
		wait_done(n, 40000);
		repeat (4) @(posedge sys_clk_i);
	endtask
	task automatic rx_frame(input logic [7:0] v, input logic n9);
		int n;
		sdata <= v;
		ninth <= n9;
		send <= 1'b1;
		@(posedge sys_clk_i);
		send <= 1'b0;
		n = 0;
		do begin @(posedge sys_clk_i); n++; end while (busy !== 1'b0 && n < 5000);
		wait_done(n, 5000);
		repeat (4) @(posedge sys_clk_i);
	endtask
	always @(posedge sys_clk_i)
		if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && rq.size() > 0)
			check(prdata_o, rq.pop_front());
	always begin
		@(negedge tx_o);
		if (!m0 && tq.size() > 0) begin
			got = 11'h7FF;
			repeat (per / 2) @(posedge sys_clk_i);
			for (int i = 0; i < (nine ? 11 : 10); i++) begin
				got[i] = tx_o;
				repeat (per) @(posedge sys_clk_i);
			end
			check(got, tq.pop_front());
		end
	end
	always @(posedge sys_clk_i) begin
		if (m0 && tx_o === 1'b0) lowc <= lowc + 1;
		if (m0 && tx_o === 1'b1 && lowc > 0) begin
			check(lowc, half);
			sh = {rx_o, sh[7:1]};
			k++;
			lowc <= 0;
			if (k == 8) begin
				check(sh, tq.pop_front());
				k = 0;
			end
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		@(posedge sys_clk_i);
		apb(0, 12'h260, 0, 32'h00);
		apb(0, 12'h21C, 0, 32'h00);
		apb(0, 12'h3FC, 0, 32'h00);
		apb(1, 12'h280, 32'h20, 0);
		apb(1, 12'h284, 32'h11, 0);
		apb(1, 12'h260, 32'h40, 0);
		d = rnd();
		tq.push_back({2'b11, d[7:0], 1'b0});
		apb(1, 12'h264, d, 0);
		drain();
		apb(0, 12'h260, 0, 32'h42);
		apb(1, 12'h288, 32'h10, 0);
		apb(1, 12'h21C, 32'h80, 0);
		apb(1, 12'h260, 32'hC8, 0);
		per = 16'd272;
		nine = 1'b1;
		d = rnd();
		tq.push_back({2'b11, d[7:0], 1'b0});
		apb(1, 12'h264, d, 0);
		drain();
		apb(0, 12'h260, 0, 32'hCA);
		apb(1, 12'h21C, 0, 0);
		per = 16'd17;
		apb(1, 12'h260, 32'hF0, 0);
		rx_frame(8'h3C, 1'b0);
		apb(0, 12'h260, 0, 32'hF0);
		apb(0, 12'h264, 0, 32'h3C);
		d = rnd();
		rx_frame(d[7:0], 1'b1);
		apb(0, 12'h260, 0, 32'hF5);
		apb(1, 12'h260, 32'hE0, 0);
		rx_frame(8'h5A, 1'b1);
		apb(0, 12'h260, 0, 32'hE0);
		apb(0, 12'h264, 0, {24'h0, d[7:0]});
		m0 = 1'b1;
		for (int r = 0; r < 2; r++) begin
			half = r ? 2 : 6;
			d = rnd();
			tq.push_back({3'b000, d[7:0]});
			apb(1, 12'h260, r ? 32'h20 : 32'h00, 0);
			apb(1, 12'h264, d, 0);
			drain();
			apb(0, 12'h260, 0, r ? 32'h22 : 32'h02);
		end
		// reserved mode sends nothing, no done flag
		apb(1, 12'h260, 32'h80, 0);
		d = rnd();
		apb(1, 12'h264, d, 0);
		repeat (40) @(posedge sys_clk_i);
		apb(0, 12'h260, 0, 32'h80);
		// write without low byte strobe is ignored
		pstrb_i <= 4'hE;
		apb(1, 12'h260, 32'hFF, 0);
		pstrb_i <= 4'hF;
		apb(0, 12'h260, 0, 32'h80);
		end_of_test();
	end
endmodule // test_uspt_serial_port

/* test/uspt_serial_partner.sv */
`timescale 1ns/1ps
module uspt_serial_partner (
	input  wire logic        sys_clk_i,
	input  wire logic        send_i,
	input  wire logic [7:0]  data_i,
	input  wire logic        ninth_i,
	input  wire logic        nine_i,
	input  wire logic [15:0] period_i,
	output logic             line_o,
	output logic             busy_o
);
	logic [10:0] frame;
	initial begin
		line_o = 1'b1;
		busy_o = 1'b0;
	end
	always @(posedge sys_clk_i) begin
		if (send_i && !busy_o) begin
			busy_o <= 1'b1;
			frame = nine_i ? {1'b1, ninth_i, data_i, 1'b0} : {2'b11, data_i, 1'b0};
			for (int b = 0; b < (nine_i ? 11 : 10); b++) begin
				line_o <= frame[b];
				repeat (period_i) @(posedge sys_clk_i);
			end
			line_o <= 1'b1;
			busy_o <= 1'b0;
		end
	end
endmodule // uspt_serial_partner

/* test/uspt_serial_port_properties.sv */
`timescale 1ns/1ps
module uspt_serial_port_properties
	import uspt_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        resetn_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        rx_oe_o,
	input wire logic        tx_o
);
	logic mapped;
	assign mapped = paddr_i inside {12'h21C, 12'h260, 12'h264, 12'h280, 12'h284, 12'h288};
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence setup_s; psel_i && !penable_i; endsequence
	sequence access_s; psel_i && penable_i && pready_o; endsequence
	ready_after_setup_a: assert property (setup_s |=> access_s) else $error("no ready after setup");
	ready_idle_a: assert property (!psel_i |=> !pready_o) else $error("ready while idle");
	error_paired_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
	unmapped_error_a: assert property (setup_s ##0 !mapped |=> pslverr_o) else $error("no error");
	mapped_ok_a: assert property (setup_s ##0 mapped |=> !pslverr_o) else $error("false error");
	read_hold_a: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
		else $error("read data moved");
	power_unread_a: assert property (setup_s ##0 (!pwrite_i && paddr_i == 12'h21C) |=> prdata_o == 32'h0)
		else $error("power register readable");
	reset_line_a: assert property ($rose(resetn_i) |-> tx_o && !rx_oe_o && !pready_o && prdata_o == 32'h0)
		else $error("bad reset state");
	clock_low_a: assert property ($fell(tx_o) |=> !tx_o) else $error("low pulse too short");
endmodule // uspt_serial_port_properties
bind uspt_serial_port uspt_serial_port_properties i_props (.sys_clk_i, .resetn_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .rx_oe_o, .tx_o);
